// ---- spi_port_consts.svh ----
// Register offsets, field positions, reset values and counts of the serial port
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH

// ****************************************
// Register byte offsets (AXI4-Lite)
// ****************************************
`define OFF_CTRL1 8'h00
`define OFF_CTRL2 8'h04
`define OFF_RATE 8'h08
`define OFF_STAT 8'h0c
`define OFF_DATA 8'h10
`define OFF_DIR 8'h14
`define OFF_PORT 8'h18

// ****************************************
// Reset values
// ****************************************
`define CTRL1_RST 8'h04
`define CTRL2_RST 1'b0
`define RATE_RST 3'h0
`define DIR_RST 4'h0
`define GPO_RST 4'h0

// ****************************************
// Field positions
// ****************************************
`define ST_DONE 7
`define ST_WRITE_COLLISION_FLAG 6
`define ST_MODE_FAULT_FLAG 4
`define PIN_MISO 0
`define PIN_MOSI 1
`define PIN_SCK 2
`define PIN_SS 3

// ****************************************
// Counts and bus answers
// ****************************************
`define EDGES_LAST 4'hf
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- spi_port_pkg.sv ----
// Types shared by the serial port design
package spi_port_pkg;

    // Control register 1 layout, bit 7 down to bit 0
    typedef struct packed {
        logic irq_en;
        logic port_enable;
        logic open_drain_select;
        logic master_select;
        logic cpol;
        logic cpha;
        logic select_output_enable;
        logic low_bit_first;
    } ctrl_s;

    // Port pins 7..4: select, clock, master out, slave out
    typedef struct packed {
        logic ss;
        logic sck;
        logic mosi;
        logic miso;
    } pin_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01
    } xfer_e;

    typedef enum logic [2:0] {
        R_CTRL1, R_CTRL2, R_RATE, R_STAT, R_DATA, R_DIR, R_PORT, R_NONE
    } reg_e;

endpackage

// ---- pin_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Raw and filtered levels
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] stable
);

    logic [WIDTH-1:0] ff1_q;
    logic [WIDTH-1:0] ff2_q;
    logic [WIDTH-1:0] ff3_q;

    // The first stage feeds only the second; it may be metastable
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ff1_q <= '0;
            ff2_q <= '0;
            ff3_q <= '0;
        end else begin
            ff1_q <= raw;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stable <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (ff2_q[i] == ff3_q[i]) begin
                    stable[i] <= ff3_q[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

// ---- spi_port.sv ----
// Serial peripheral port, master or slave, with AXI4-Lite registers
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_consts.svh"

// Operation
// - Master bit clock is bus clock over 2..256, power of two, three-bit field
// - Rate divider runs only in master mode during a transfer
// - Each transfer shifts eight bits, exchanging bytes with the partner
// - Written byte goes out; data read returns byte received
// - Polarity inverts clock; phase picks shifted or unshifted sampling
// - Idle master clock sits at the polarity level
// - Select output low while transferring, high while idle
// - Master select pin role from direction bit and select-output enable
// - Enabled port: inputs always inputs; outputs drive only if direction set
// - Bidirectional mode uses one data pin per role, direction bit steers
// - Serial-pin control bit selects bidirectional pin configurations
// - Enable clear resets port logic; set claims pins 4 to 7
// - Mode fault forces enable and master to read zero
// - Open-drain bit makes pins 4 to 7 drive low only
// - Master-select 0 is slave, 1 is master
// - Bit order selects MSB or LSB first; register keeps MSB at 7
// - Interrupt when enabled and transfer-done or mode fault set
// - Done flag after eighth clock; cleared by status read then data access
// - Mode fault when master sees select low, unless select drives
// - Data write during transfer blocked, sets collision flag, no interrupt
module spi_port
    import spi_port_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Port pins 7..4
    input wire pin_s pin_i,
    output var pin_s pin_o,
    output var pin_s pin_oe,
    // Interrupt request
    output logic irq
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic reg_e decode(input logic [7:0] a);
        case (a)
            `OFF_CTRL1: decode = R_CTRL1;
            `OFF_CTRL2: decode = R_CTRL2;
            `OFF_RATE: decode = R_RATE;
            `OFF_STAT: decode = R_STAT;
            `OFF_DATA: decode = R_DATA;
            `OFF_DIR: decode = R_DIR;
            `OFF_PORT: decode = R_PORT;
            default: decode = R_NONE;
        endcase
    endfunction

    // Bit that leaves the shifter next
    function automatic logic top_bit(input logic [7:0] v, input logic lsb);
        top_bit = lsb ? v[0] : v[7];
    endfunction

    // Shift one bit in at the far end; MSB stays at bit 7 either way
    function automatic logic [7:0] shift_in(input logic [7:0] v,
                                            input logic b, input logic lsb);
        shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction

    // ****************************************
    // Registers and state
    // ****************************************
    ctrl_s ctrl_q;
    logic bidi_q;
    logic [2:0] rate_q;
    logic [3:0] dir_q;
    logic [3:0] gpo_q;
    logic done_q, write_collision_flag_q, mode_fault_flag_q;
    logic done_arm_q, write_collision_flag_arm_q, mode_fault_flag_arm_q;
    xfer_e st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, rx_q, div_q;
    logic rbit_q, dout_q, sck_q, sck_prev_q, ss_hold_q;
    logic aw_got_q, w_got_q, wst_q;
    logic [7:0] aw_addr_q, wd_q;
    pin_s ps;
    logic [3:0] ov, oe;

    logic en_eff, mst, busy, tick, ev, lead, din, smp;
    logic wr_fire, wr_en, rd_fire, data_wr, data_acc, done_ev;
    logic [7:0] nxt;
    reg_e wr_sel, rd_sel;

    pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .raw(pin_i),
        .stable(ps)
    );

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready = !w_got_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_got_q && w_got_q;
    assign wr_sel = decode(aw_addr_q);
    assign wr_en = wr_fire && wst_q;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_sel = decode(s_axi_araddr);

    // Address and data are caught in either order
    always_ff @(posedge clk_sys) begin
        if (reset || wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
            end
        end
    end

    // Payload capture; only byte lane 0 holds register bits
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            aw_addr_q <= '0;
            wd_q <= '0;
            wst_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_q <= s_axi_wdata[7:0];
                wst_q <= s_axi_wstrb[0];
            end
        end
    end

    // Write response one cycle after both halves are held
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == R_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read data; enable and master read zero under mode fault
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (rd_sel == R_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            s_axi_rdata <= '0;
            case (rd_sel)
                R_CTRL1: s_axi_rdata[7:0] <= {ctrl_q.irq_en, en_eff,
                    ctrl_q[5], mst, ctrl_q[3:0]};
                R_CTRL2: s_axi_rdata[0] <= bidi_q;
                R_RATE: s_axi_rdata[2:0] <= rate_q;
                R_STAT: begin
                    s_axi_rdata[`ST_DONE] <= done_q;
                    s_axi_rdata[`ST_WRITE_COLLISION_FLAG] <= write_collision_flag_q;
                    s_axi_rdata[`ST_MODE_FAULT_FLAG] <= mode_fault_flag_q;
                end
                R_DATA: s_axi_rdata[7:0] <= rx_q;
                R_DIR: s_axi_rdata[3:0] <= dir_q;
                R_PORT: s_axi_rdata[3:0] <= ps;
                default: s_axi_rdata <= '0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Software-written configuration
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_q <= ctrl_s'(`CTRL1_RST);
            bidi_q <= `CTRL2_RST;
            rate_q <= `RATE_RST;
            dir_q <= `DIR_RST;
            gpo_q <= `GPO_RST;
        end else if (wr_en) begin
            case (wr_sel)
                R_CTRL1: ctrl_q <= ctrl_s'(wd_q);
                R_CTRL2: bidi_q <= wd_q[0];
                R_RATE: rate_q <= wd_q[2:0];
                R_DIR: dir_q <= wd_q[3:0];
                R_PORT: gpo_q <= wd_q[3:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    assign data_wr = wr_en && (wr_sel == R_DATA);
    assign data_acc = (rd_fire && rd_sel == R_DATA)
                    || (wr_fire && wr_sel == R_DATA);

    // Status read arms a clear; a set in the clearing cycle wins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            {done_q, write_collision_flag_q, mode_fault_flag_q} <= 3'h0;
            {done_arm_q, write_collision_flag_arm_q, mode_fault_flag_arm_q} <= 3'h0;
        end else begin
            done_q <= done_ev
                || (done_q && !(data_acc && done_arm_q));
            write_collision_flag_q <= (data_wr && busy)
                || (write_collision_flag_q && !(data_acc && write_collision_flag_arm_q));
            mode_fault_flag_q <= (ctrl_q.port_enable && ctrl_q.master_select
                && !dir_q[`PIN_SS] && !ps.ss)
                || (mode_fault_flag_q && !(wr_fire && wr_sel == R_CTRL1
                && mode_fault_flag_arm_q));
            if (rd_fire && rd_sel == R_STAT) begin
                done_arm_q <= done_q;
                write_collision_flag_arm_q <= write_collision_flag_q;
                mode_fault_flag_arm_q <= mode_fault_flag_q;
            end else begin
                if (data_acc) begin
                    done_arm_q <= 1'b0;
                    write_collision_flag_arm_q <= 1'b0;
                end
                if (wr_fire && wr_sel == R_CTRL1) begin
                    mode_fault_flag_arm_q <= 1'b0;
                end
            end
        end
    end

    // Collision raises no request; only done and fault do
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= ctrl_q.irq_en && (done_q || mode_fault_flag_q);
        end
    end

    // ****************************************
    // Rate divider and shifter
    // ****************************************
    assign en_eff = ctrl_q.port_enable && !mode_fault_flag_q;
    assign mst = ctrl_q.master_select && !mode_fault_flag_q;
    assign busy = (st_q == ST_SHIFT);
    // Half a bit period is 2^rate cycles, so the divisor is 2^(rate+1)
    assign tick = mst && busy
        && (div_q == (8'h01 << rate_q) - 8'h01);
    assign ev = en_eff && (mst ? tick
        : (!ps.ss && ps.sck != sck_prev_q));
    assign lead = !cnt_q[0];
    assign din = mst ? (bidi_q ? ps.mosi : ps.miso)
                     : (bidi_q ? ps.miso : ps.mosi);
    assign smp = ctrl_q.cpha ? din : rbit_q;
    assign nxt = shift_in(sh_q, smp, ctrl_q.low_bit_first);
    assign done_ev = ev && !lead && cnt_q == `EDGES_LAST;

    // Divider held at zero unless a master transfer runs, saving power
    always_ff @(posedge clk_sys) begin
        if (reset || !(mst && busy) || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // Previous filtered clock level, for slave edge finding
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= ps.sck;
        end
    end

    // Select stays low one cycle past the last clock edge, so the far
    // end still sees that edge inside its frame
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ss_hold_q <= 1'b0;
        end else begin
            ss_hold_q <= busy;
        end
    end

    // Sixteen clock edges move eight bits each way
    always_ff @(posedge clk_sys) begin
        if (reset || !en_eff || (!mst && ps.ss)) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            sck_q <= 1'b0;
            rbit_q <= 1'b0;
        end else if (data_wr && !busy) begin
            st_q <= mst ? ST_SHIFT : ST_IDLE;
            cnt_q <= '0;
            sck_q <= 1'b0;
        end else if (ev) begin
            st_q <= ST_SHIFT;
            cnt_q <= cnt_q + 4'h1;
            sck_q <= mst ? !sck_q : 1'b0;
            if (lead && !ctrl_q.cpha) begin
                rbit_q <= din;
            end
            if (!lead && cnt_q == `EDGES_LAST) begin
                st_q <= ST_IDLE;
            end
        end
    end

    // Shifter, output bit and receive buffer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sh_q <= '0;
            dout_q <= 1'b0;
            rx_q <= '0;
        end else if (data_wr && !busy) begin
            sh_q <= wd_q;
            dout_q <= top_bit(wd_q, ctrl_q.low_bit_first);
        end else if (ev) begin
            if (lead) begin
                if (ctrl_q.cpha) begin
                    dout_q <= top_bit(sh_q, ctrl_q.low_bit_first);
                end
            end else begin
                sh_q <= nxt;
                if (!ctrl_q.cpha) begin
                    dout_q <= top_bit(nxt, ctrl_q.low_bit_first);
                end
                if (cnt_q == `EDGES_LAST) begin
                    rx_q <= nxt;
                end
            end
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    // Port defaults to general-purpose I/O under the direction bits
    always_comb begin
        ov = gpo_q;
        oe = dir_q;
        if (en_eff) begin
            if (mst) begin
                oe[`PIN_MISO] = bidi_q && dir_q[`PIN_MISO];
                ov[`PIN_MOSI] = dout_q;
                ov[`PIN_SCK] = sck_q ^ ctrl_q.cpol;
                if (dir_q[`PIN_SS] && ctrl_q.select_output_enable) begin
                    ov[`PIN_SS] = !(busy || ss_hold_q);
                end
            end else begin
                ov[`PIN_MISO] = dout_q;
                oe[`PIN_MISO] = dir_q[`PIN_MISO] && !ps.ss;
                oe[`PIN_MOSI] = bidi_q && dir_q[`PIN_MOSI];
                oe[`PIN_SCK] = 1'b0;
                oe[`PIN_SS] = 1'b0;
            end
        end
        if (ctrl_q.open_drain_select) begin
            oe = oe & ~ov;
            ov = '0;
        end
    end

    // Registered so pins never glitch on decode changes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_o <= '0;
            pin_oe <= '0;
        end else begin
            pin_o <= ov;
            pin_oe <= oe;
        end
    end

endmodule

`default_nettype wire

// ---- spi_port_props.sv ----
// Concurrent checks on the serial port's bus handshakes and pin frames
`timescale 1ns/10ps
`default_nettype none
module spi_port_props
    import spi_port_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and interrupt
    input wire pin_s pin_o,
    input wire pin_s pin_oe,
    input wire logic irq
);
    // ****************************************
    // Frame tracking
    // ****************************************
    // Wire levels with a pull-up, so open-drain drive counts the same
    logic ss_lvl;
    logic sck_lvl;
    logic sck_q;
    logic [4:0] edge_q;
    assign ss_lvl = !pin_oe.ss || pin_o.ss;
    assign sck_lvl = !pin_oe.sck || pin_o.sck;
    // Clock edges are counted only while the select output is low
    always_ff @(posedge clk_sys) begin
        sck_q <= sck_lvl;
        if (reset || ss_lvl) begin
            edge_q <= 5'h00;
        end else if (sck_lvl != sck_q) begin
            edge_q <= edge_q + 5'h01;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write response late");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read response late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read response changed early");
    property p_one_write;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_one_write: assert property (p_one_write)
        else $error("write accepted while answering");
    property p_reset_quiet;
        disable iff (1'b0) reset |=> !s_axi_bvalid && !s_axi_rvalid
            && pin_oe == 4'h0 && !irq;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active after reset");
    property p_sixteen_edges;
        $rose(ss_lvl) |-> edge_q == 5'h10;
    endproperty
    a_sixteen_edges: assert property (p_sixteen_edges)
        else $error("frame without sixteen clock edges");
    property p_select_clocks;
        $fell(ss_lvl) |-> ##[1:300] (sck_lvl != sck_q);
    endproperty
    a_select_clocks: assert property (p_select_clocks)
        else $error("select low without clocking");
endmodule

bind spi_port spi_port_props u_props (.clk_sys(clk_sys), .reset(reset),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_o(pin_o), .pin_oe(pin_oe),
    .irq(irq));
`default_nettype wire

// ---- spi_partner.sv ----
// Behavioural far-end slave that swaps one byte per select frame
`timescale 1ns/10ps
`default_nettype none
module spi_partner (
    // Wire levels at the far end
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_en,
    // Format and data
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    logic [7:0] sh = 8'h00;
    logic bit_in = 1'b0;
    initial miso = 1'b1;
    initial rx_byte = 8'h00;
    // Data line released outside frames; the wire's pull-up takes over
    assign miso_en = !ss_n;
    // Load presents the first bit for phase 0
    always @(negedge ss_n) begin
        sh = tx_byte;
        miso = lsb ? sh[0] : sh[7];
    end
    // Leading edge samples (phase 0) or presents (phase 1); trailing shifts
    always @(sck) begin
        if (!ss_n && sck != cpol) begin
            if (cpha) miso = lsb ? sh[0] : sh[7];
            else bit_in = mosi;
        end else if (!ss_n) begin
            if (cpha) bit_in = mosi;
            sh = lsb ? {bit_in, sh[7:1]} : {sh[6:0], bit_in};
            if (!cpha) miso = lsb ? sh[0] : sh[7];
        end
    end
    // Byte taken whole once the select returns high
    always @(posedge ss_n) rx_byte = sh;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Register-level testbench of the serial port against a far-end slave
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_consts.svh"
module tb_top
    import spi_port_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] awa = 8'h00;
    logic awv = 1'b0;
    logic [31:0] wd = 32'h0;
    logic wv = 1'b0;
    logic [7:0] ara = 8'h00;
    logic arv = 1'b0;
    logic awr, wrd, bv, arr, rv, irq, miso_m, miso_en, ss_low = 1'b0;
    logic [1:0] bresp, resp;
    logic [31:0] rdat, d;
    pin_s pin_i, pin_o, pin_oe;
    logic p_cpol = 1'b0, p_cpha = 1'b0, p_lsb = 1'b0, sck_q = 1'b0;
    logic [7:0] p_tx = 8'h00, p_rx, ctl, mtx;
    logic [7:0] offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
    int err_count = 0, n_tests = 0, gap = 0, run = 0, t;
    always #20 clk_sys = !clk_sys;
    spi_port u_dut (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(resp), .s_axi_rvalid(rv),
        .s_axi_rready(1'b1), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .irq(irq));
    spi_partner u_far (.sck(pin_i.sck), .ss_n(pin_i.ss), .mosi(pin_i.mosi),
        .miso(miso_m), .miso_en(miso_en), .cpol(p_cpol), .cpha(p_cpha),
        .lsb(p_lsb), .tx_byte(p_tx), .rx_byte(p_rx));
    // Every pin has a pull-up; the bench may pull the select low
    always_comb begin
        pin_i.ss = pin_oe.ss ? pin_o.ss : !ss_low;
        pin_i.sck = pin_oe.sck ? pin_o.sck : 1'b1;
        pin_i.mosi = pin_oe.mosi ? pin_o.mosi : 1'b1;
        pin_i.miso = pin_oe.miso ? pin_o.miso : (miso_en ? miso_m : 1'b1);
    end
    // Cycles between the last two clock wire changes
    always @(posedge clk_sys) begin
        sck_q <= pin_i.sck;
        if (pin_i.sck != sck_q) begin
            gap <= run;
            run <= 1;
        end else begin
            run <= run + 1;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Write one register; address and data are offered together
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        awa <= a;
        wd <= {24'h000000, v};
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
        end while (!bv);
    endtask
    // Read one register; data and response taken with the answer
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        ara <= a;
        arv <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        v = rdat;
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard, several times the longest expected run
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        $display("MISMATCH at %0t: run did not finish", $time);
        close_out;
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(offs[i], d);
            chk(d, i == 0 ? 32'h04 : 32'h00);
        end
        chk(32'(pin_oe), 32'h0);
        rd(8'h1c, d);
        chk(32'(resp), 32'h2);
        rd(`OFF_PORT, d);
        chk(d, 32'hf);
        $display("reset values test done");
        wr(`OFF_PORT, 8'h08); // Select latch high before it drives
        wr(`OFF_DIR, 8'h0e);
        // All four clock formats, both bit orders, four rates
        for (int m = 0; m < 4; m++) begin
            ctl = {4'hd, m[1], m[0], 1'b1, m[1] ^ m[0]};
            ctl[5] = (m == 3);
            mtx = 8'h1d + 8'(m);
            p_tx <= 8'hb4 - 8'(m);
            p_cpol <= m[1];
            p_cpha <= m[0];
            p_lsb <= m[1] ^ m[0];
            wr(`OFF_RATE, 8'(m + 3));
            wr(`OFF_CTRL1, ctl);
            repeat (4) @(posedge clk_sys);
            chk(32'(pin_i.sck), 32'(m[1]));
            chk(32'(pin_i.ss), 32'h1);
            if (m == 3) chk(32'(pin_oe.ss), 32'h0);
            wr(`OFF_DATA, mtx);
            wr(`OFF_DATA, 8'hff);
            @(posedge clk_sys);
            chk(32'(irq), 32'h0);
            t = 0;
            do begin
                rd(`OFF_STAT, d);
                t++;
            end while (d[7] !== 1'b1 && t < 2000);
            chk(d, 32'hc0);
            chk(32'(irq), 32'h1);
            rd(`OFF_DATA, d);
            chk(d, 32'(8'hb4 - 8'(m)));
            rd(`OFF_STAT, d);
            chk(d, 32'h0);
            chk(32'(p_rx), 32'(mtx));
            chk(32'(gap), 32'(1 << (m + 3)));
            chk(32'(pin_i.sck), 32'(m[1]));
        end
        $display("transfer format test done");
        // Select pulled low while master with select as input
        wr(`OFF_DIR, 8'h06);
        wr(`OFF_CTRL1, 8'hd4);
        ss_low <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(`OFF_STAT, d);
        chk(d, 32'h10);
        rd(`OFF_CTRL1, d);
        chk(d, 32'h84);
        chk(32'(irq), 32'h1);
        ss_low <= 1'b0;
        repeat (8) @(posedge clk_sys);
        wr(`OFF_CTRL1, 8'h04);
        rd(`OFF_STAT, d);
        chk(d, 32'h0);
        $display("mode fault test done");
        close_out;
    end
endmodule
`default_nettype wire
